// >>> inc/rtcrw_defines.vh
`ifndef RTCRW_DEFINES_VH
`define RTCRW_DEFINES_VH

// ****************************************************************
// register byte offsets on the bus
// ****************************************************************
`define RTCRW_OFS_CLK_CFG     8'h00
`define RTCRW_OFS_TIME_WIN    8'h04
`define RTCRW_OFS_ALRM_CFG    8'h08
`define RTCRW_OFS_ALRM_WIN    8'h0c
`define RTCRW_OFS_PWR_CTRL    8'h10
`define RTCRW_OFS_UNLOCK_KEY  8'h14

// ****************************************************************
// field positions
// ****************************************************************
`define RTCRW_PTR_LSB         8
`define RTCRW_PTR_MSB         9
`define RTCRW_WREN_BIT        13
`define RTCRW_CSEL_LSB        0
`define RTCRW_CSEL_MSB        1

// ****************************************************************
// reset values and special codes
// ****************************************************************
`define RTCRW_PTR_RESET       2'h0
`define RTCRW_PTR_FLOOR       2'h0
`define RTCRW_PTR_STEP        2'h1
`define RTCRW_CSEL_RESET      2'h0
`define RTCRW_BYTE_RESET      8'h00
`define RTCRW_KEY_FIRST       8'h55
`define RTCRW_KEY_SECOND      8'haa
`define RTCRW_TIME_UNUSED_IDX 7
`define RTCRW_ENTRIES         8

// ****************************************************************
// ahb-lite codes
// ****************************************************************
`define RTCRW_HTRANS_NONSEQ   2'h2
`define RTCRW_HSIZE_BYTE      3'h0
`define RTCRW_HSIZE_HALF      3'h1
`define RTCRW_HRESP_OKAY      1'h0

`endif

// >>> rtl/rtcrw_top.v
// Our own choices: the AHB-Lite interface to the registers and the address map.

`default_nettype none
`include "rtcrw_defines.vh"

module rtcrw_top (
    input  wire        clk_in,               // system clock, 50 MHz
    input  wire        nrst_in,              // synchronous reset, active low
    input  wire        hsel_in,              // slave select
    input  wire [31:0] haddr_in,             // byte address
    input  wire [1:0]  htrans_in,            // transfer type
    input  wire        hwrite_in,            // write when high
    input  wire [2:0]  hsize_in,             // transfer size
    input  wire [31:0] hwdata_in,            // write data
    input  wire        hready_in,            // bus ready
    output reg  [31:0] hrdata_out,           // read data
    output reg         hreadyout_out,        // slave ready
    output reg         hresp_out,            // always okay
    output reg  [1:0]  clock_source_select_out, // selected clock source
    output reg         time_write_enable_out    // time write-enable state
);

    // ****************************************************************
    // data phase capture
    // ****************************************************************
    reg        dph_valid;                    // a transfer is in data phase
    reg        dph_write;                    // that transfer writes
    reg  [7:0] dph_addr;                     // its byte offset
    reg  [2:0] dph_size;                     // its size
    reg  [1:0] dph_lo2;                      // its low address bits
    reg        rd_wait;                      // read data being produced

    // ****************************************************************
    // programmer state
    // ****************************************************************
    reg  [1:0] time_window_pointer;          // time pair selector
    reg  [1:0] alarm_window_pointer;         // alarm pair selector
    reg        key_armed;                    // first key seen
    reg        unlock_window;                // one-access unlock slot

    wire       addr_take;                    // address phase accepted
    wire       lane_lo;                      // bits 7:0 touched
    wire       lane_hi;                      // bits 15:8 touched
    wire       wr_done;                      // write data phase ends now
    wire       rd_done;                      // read data produced now
    wire       wr_clk_cfg;                   // write to clock config
    wire       wr_alrm_cfg;                  // write to alarm config
    wire       wr_pwr;                       // write to power control
    wire       wr_key;                       // write to unlock key
    wire       wr_time;                      // write to time window
    wire       wr_alrm;                      // write to alarm window
    wire       rd_time;                      // read of time window
    wire       rd_alrm;                      // read of alarm window
    wire [2:0] time_lo_idx;                  // time entry on low byte
    wire [2:0] time_hi_idx;                  // time entry on high byte
    wire [2:0] alrm_lo_idx;                  // alarm entry on low byte
    wire [2:0] alrm_hi_idx;                  // alarm entry on high byte
    wire [63:0] time_flat;                   // all time entries
    wire [63:0] alrm_flat;                   // all alarm entries

    // ****************************************************************
    // bus decode
    // ****************************************************************

    // an address phase is taken only while the bus is ready
    assign addr_take = hsel_in && hready_in && (htrans_in == `RTCRW_HTRANS_NONSEQ);

    // byte lanes follow size and the low address bits
    assign lane_lo = (dph_size == `RTCRW_HSIZE_BYTE) ? (dph_lo2 == 2'h0) :
                     (dph_size == `RTCRW_HSIZE_HALF) ? (dph_lo2[1] == 1'b0) : 1'b1;
    assign lane_hi = (dph_size == `RTCRW_HSIZE_BYTE) ? (dph_lo2 == 2'h1) :
                     (dph_size == `RTCRW_HSIZE_HALF) ? (dph_lo2[1] == 1'b0) : 1'b1;

    // writes complete at the end of their single data phase cycle
    assign wr_done     = dph_valid && dph_write;
    // reads complete in their first, stalled data phase cycle
    assign rd_done     = rd_wait;

    assign wr_clk_cfg  = wr_done && (dph_addr == `RTCRW_OFS_CLK_CFG);
    assign wr_alrm_cfg = wr_done && (dph_addr == `RTCRW_OFS_ALRM_CFG);
    assign wr_pwr      = wr_done && (dph_addr == `RTCRW_OFS_PWR_CTRL);
    assign wr_key      = wr_done && (dph_addr == `RTCRW_OFS_UNLOCK_KEY) && lane_lo;
    assign wr_time     = wr_done && (dph_addr == `RTCRW_OFS_TIME_WIN);
    assign wr_alrm     = wr_done && (dph_addr == `RTCRW_OFS_ALRM_WIN);
    assign rd_time     = rd_done && (dph_addr == `RTCRW_OFS_TIME_WIN);
    assign rd_alrm     = rd_done && (dph_addr == `RTCRW_OFS_ALRM_WIN);

    // ****************************************************************
    // window mapping: high byte takes the odd entry of each pair
    // ****************************************************************
    assign time_lo_idx = {time_window_pointer, 1'b0};
    assign time_hi_idx = {time_window_pointer, 1'b1};
    assign alrm_lo_idx = {alarm_window_pointer, 1'b0};
    assign alrm_hi_idx = {alarm_window_pointer, 1'b1};

    // ****************************************************************
    // value storage, one generate entry per byte
    // ****************************************************************
    // time entries: 0 seconds, 1 minutes, 2 hours, 3 weekday,
    // 4 day, 5 month, 6 year, 7 unused and reads zero
    // alarm entries: 0 seconds, 1 minutes, 2 hours, 3 weekday,
    // 4 day, 5 month, 6 power sample, 7 power stability
    genvar gi;
    generate
        for (gi = 0; gi < `RTCRW_ENTRIES; gi = gi + 1) begin : g_entry
            reg [7:0] alrm_q;                // alarm byte
            // alarm writes carry no lock
            always @(posedge clk_in) begin
                if (!nrst_in) begin
                    alrm_q <= `RTCRW_BYTE_RESET;
                end else if (wr_alrm && lane_lo && (alrm_lo_idx == gi)) begin
                    alrm_q <= hwdata_in[7:0];
                end else if (wr_alrm && lane_hi && (alrm_hi_idx == gi)) begin
                    alrm_q <= hwdata_in[15:8];
                end
            end
            assign alrm_flat[8*gi +: 8] = alrm_q;

            if (gi == `RTCRW_TIME_UNUSED_IDX) begin : g_unused
                // no storage behind the unused high byte
                assign time_flat[8*gi +: 8] = `RTCRW_BYTE_RESET;
            end else begin : g_time
                reg [7:0] time_q;            // time byte
                // a locked write is dropped, the value stays
                always @(posedge clk_in) begin
                    if (!nrst_in) begin
                        time_q <= `RTCRW_BYTE_RESET;
                    end else if (wr_time && time_write_enable_out) begin
                        if (lane_lo && (time_lo_idx == gi)) begin
                            time_q <= hwdata_in[7:0];
                        end else if (lane_hi && (time_hi_idx == gi)) begin
                            time_q <= hwdata_in[15:8];
                        end
                    end
                end
                assign time_flat[8*gi +: 8] = time_q;
            end
        end
    endgenerate

    // ****************************************************************
    // bus handshake and read data
    // ****************************************************************

    // reads stall one cycle so that a write in the prior data phase
    // is already visible; writes never stall
    always @(posedge clk_in) begin
        if (!nrst_in) begin
            dph_valid     <= 1'b0;
            dph_write     <= 1'b0;
            dph_addr      <= 8'h00;
            dph_size      <= 3'h0;
            dph_lo2       <= 2'h0;
            rd_wait       <= 1'b0;
            hreadyout_out <= 1'b1;
            hresp_out     <= `RTCRW_HRESP_OKAY;
            hrdata_out    <= 32'h0000_0000;
        end else begin
            hresp_out <= `RTCRW_HRESP_OKAY;
            rd_wait   <= 1'b0;
            if (rd_wait) begin
                // second read cycle: data out, bus released
                hreadyout_out <= 1'b1;
                dph_valid     <= 1'b0;
            end else if (addr_take) begin
                // new address phase: latch it for the data phase
                dph_valid     <= 1'b1;
                dph_write     <= hwrite_in;
                dph_addr      <= {haddr_in[7:2], 2'h0};
                dph_size      <= hsize_in;
                dph_lo2       <= haddr_in[1:0];
                hreadyout_out <= hwrite_in;
                rd_wait       <= !hwrite_in;
            end else begin
                dph_valid     <= 1'b0;
                hreadyout_out <= 1'b1;
            end
            // read data is formed in the stall cycle from current state
            if (rd_wait) begin
                case (dph_addr)
                    `RTCRW_OFS_CLK_CFG: begin
                        hrdata_out <= {18'h00000, time_write_enable_out, 3'h0,
                                       time_window_pointer, 8'h00};
                    end
                    `RTCRW_OFS_ALRM_CFG: begin
                        hrdata_out <= {22'h000000, alarm_window_pointer, 8'h00};
                    end
                    `RTCRW_OFS_TIME_WIN: begin
                        hrdata_out <= {16'h0000, time_flat[8*time_hi_idx +: 8],
                                       time_flat[8*time_lo_idx +: 8]};
                    end
                    `RTCRW_OFS_ALRM_WIN: begin
                        hrdata_out <= {16'h0000, alrm_flat[8*alrm_hi_idx +: 8],
                                       alrm_flat[8*alrm_lo_idx +: 8]};
                    end
                    `RTCRW_OFS_PWR_CTRL: begin
                        hrdata_out <= {30'h00000000, clock_source_select_out};
                    end
                    default: begin
                        // key register and unmapped offsets read zero
                        hrdata_out <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // window pointers
    // ****************************************************************

    // a software write sets the pointer; a high byte write or any read
    // steps it down and it sticks at the floor. byte and word reads
    // look the same, so a read always counts once
    always @(posedge clk_in) begin
        if (!nrst_in) begin
            time_window_pointer <= `RTCRW_PTR_RESET;
        end else if (wr_clk_cfg && lane_hi) begin
            time_window_pointer <= hwdata_in[`RTCRW_PTR_MSB:`RTCRW_PTR_LSB];
        end else if (rd_time || (wr_time && lane_hi)) begin
            if (time_window_pointer != `RTCRW_PTR_FLOOR) begin
                time_window_pointer <= time_window_pointer - `RTCRW_PTR_STEP;
            end
        end
    end

    // same behaviour for the alarm pointer
    always @(posedge clk_in) begin
        if (!nrst_in) begin
            alarm_window_pointer <= `RTCRW_PTR_RESET;
        end else if (wr_alrm_cfg && lane_hi) begin
            alarm_window_pointer <= hwdata_in[`RTCRW_PTR_MSB:`RTCRW_PTR_LSB];
        end else if (rd_alrm || (wr_alrm && lane_hi)) begin
            if (alarm_window_pointer != `RTCRW_PTR_FLOOR) begin
                alarm_window_pointer <= alarm_window_pointer - `RTCRW_PTR_STEP;
            end
        end
    end

    // ****************************************************************
    // unlock sequence and write-enable
    // ****************************************************************

    // the slot opens after 55h then aah and closes at the end of the
    // very next transfer, whatever it is; a stray access between the
    // two keys disarms the sequence
    always @(posedge clk_in) begin
        if (!nrst_in) begin
            key_armed     <= 1'b0;
            unlock_window <= 1'b0;
        end else if (wr_key) begin
            key_armed     <= (hwdata_in[7:0] == `RTCRW_KEY_FIRST);
            unlock_window <= key_armed && (hwdata_in[7:0] == `RTCRW_KEY_SECOND);
        end else if (wr_done || rd_done) begin
            key_armed     <= 1'b0;
            unlock_window <= 1'b0;
        end
    end

    // clearing is always allowed; setting needs the open slot, which
    // keeps a runaway program from unlocking the clock
    always @(posedge clk_in) begin
        if (!nrst_in) begin
            time_write_enable_out <= 1'b0;
        end else if (wr_clk_cfg && lane_hi) begin
            if (!hwdata_in[`RTCRW_WREN_BIT]) begin
                time_write_enable_out <= 1'b0;
            end else if (unlock_window) begin
                time_write_enable_out <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // clock source select
    // ****************************************************************

    // 00 secondary osc, 01 low-power rc, 10 ext 50 hz, 11 ext 60 hz
    always @(posedge clk_in) begin
        if (!nrst_in) begin
            clock_source_select_out <= `RTCRW_CSEL_RESET;
        end else if (wr_pwr && lane_lo) begin
            clock_source_select_out <= hwdata_in[`RTCRW_CSEL_MSB:`RTCRW_CSEL_LSB];
        end
    end

endmodule // rtcrw_top

`default_nettype wire

// >>> testbench/rtcrw_top_assertions.sv
`default_nettype none
`include "rtcrw_defines.vh"

module rtcrw_checker (
    input wire logic        clk_in,
    input wire logic        nrst_in,
    input wire logic        hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0]  htrans_in,
    input wire logic        hwrite_in,
    input wire logic [2:0]  hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic        hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic        hreadyout_out,
    input wire logic        hresp_out,
    input wire logic [1:0]  clock_source_select_out,
    input wire logic        time_write_enable_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // helper logic: which write is in its data phase
    // ****************************************************************
    logic       wr_dph;  // a write data phase ends at this edge
    logic [7:0] wr_ofs;  // its word offset
    wire        cfg_wr = wr_dph && (wr_ofs == `RTCRW_OFS_CLK_CFG);   // clock config write
    wire        pwr_wr = wr_dph && (wr_ofs == `RTCRW_OFS_PWR_CTRL);  // power control write
    // address phase is only taken while hready is high
    always @(posedge clk_in) begin
        if (!nrst_in) begin
            wr_dph <= 1'b0;
            wr_ofs <= 8'h00;
        end else if (hready_in) begin
            wr_dph <= hsel_in && (htrans_in == `RTCRW_HTRANS_NONSEQ) && hwrite_in;
            wr_ofs <= {haddr_in[7:2], 2'b00};
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    // ****************************************************************
    // properties
    // ****************************************************************
    sequence s_taken_rd;
        hsel_in && hready_in && (htrans_in == `RTCRW_HTRANS_NONSEQ) && !hwrite_in;
    endsequence
    sequence s_taken_wr;
        hsel_in && hready_in && (htrans_in == `RTCRW_HTRANS_NONSEQ) && hwrite_in;
    endsequence
    sequence s_one_wait;
        !hreadyout_out ##1 hreadyout_out;
    endsequence
    AST_READ_WAIT: assert property (s_taken_rd |=> s_one_wait)
        else $error("read without exactly one wait state");
    AST_WRITE_NOWAIT: assert property (s_taken_wr |=> hreadyout_out)
        else $error("write data phase was stretched");
    AST_RDATA_HOLD: assert property (!$rose(hreadyout_out) |-> $stable(hrdata_out))
        else $error("read data moved outside a read answer");
    AST_CSEL_WRITE: assert property (pwr_wr |=> clock_source_select_out == $past(hwdata_in[1:0]))
        else $error("clock source did not follow the write");
    AST_CSEL_HOLD: assert property (!pwr_wr |=> $stable(clock_source_select_out))
        else $error("clock source moved without a write");
    AST_WREN_CLEAR: assert property (cfg_wr && !hwdata_in[13] |=> !time_write_enable_out)
        else $error("write enable not cleared");
    AST_WREN_CAUSE: assert property ($rose(time_write_enable_out) |-> $past(cfg_wr) && $past(hwdata_in[13]))
        else $error("write enable rose without a config write");
    AST_WREN_HOLD: assert property (!cfg_wr |=> $stable(time_write_enable_out))
        else $error("write enable moved without a config write");
endmodule // rtcrw_checker

bind rtcrw_top rtcrw_checker u_chk (.clk_in(clk_in), .nrst_in(nrst_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
    .hwdata_in(hwdata_in), .hready_in(hready_in), .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .clock_source_select_out(clock_source_select_out),
    .time_write_enable_out(time_write_enable_out));
`default_nettype wire

// >>> testbench/rtcrw_top_tb.sv
`default_nettype none
`include "rtcrw_defines.vh"

module rtcrw_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_in = 1'b0;  // 50 MHz system clock
    logic        nrst_in = 1'b0; // reset, active low
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    wire  [31:0] hrdata;
    wire         hrdyo;
    wire  [1:0]  csel_o;
    wire         wren_o;
    wire         hresp;          // bus response, okay is expected throughout
    int          fail_count = 0;
    int          n_checks = 0;
    int          tv[8], av[8], tp, ap, csel, wren, ks;  // reference model state
    logic [31:0] g, e;
    int          i;
    always #10 clk_in = ~clk_in;
    rtcrw_top dut (.clk_in(clk_in), .nrst_in(nrst_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
        .hready_in(hrdyo), .hrdata_out(hrdata), .hreadyout_out(hrdyo), .hresp_out(hresp),
        .clock_source_select_out(csel_o), .time_write_enable_out(wren_o));
    // ****************************************************************
    // reference model, one call per completed transfer
    // ****************************************************************
    function automatic logic [31:0] mdl(input logic w, input logic [7:0] a, input logic [2:0] s,
                                        input logic [31:0] d);
        logic [31:0] r;
        logic        lo, hi, slot;
        r = 32'h0;
        slot = (ks == 2);
        lo = (a[1:0] == 2'h0);
        // a half word only reaches the window bytes from the lower lane pair
        hi = (s == `RTCRW_HSIZE_BYTE) ? (a[1:0] == 2'h1) :
             (s == `RTCRW_HSIZE_HALF) ? !a[1] : 1'b1;
        case ({a[7:2], 2'b00})
            `RTCRW_OFS_CLK_CFG: if (w) begin
                tp = d[9:8];
                wren = d[13] ? (wren | slot) : 0;
            end else r = (wren << 13) | (tp << 8);
            `RTCRW_OFS_ALRM_CFG: if (w) ap = d[9:8]; else r = ap << 8;
            `RTCRW_OFS_PWR_CTRL: if (w) csel = d[1:0]; else r = csel;
            `RTCRW_OFS_TIME_WIN: begin
                if (!w) r = (tv[tp*2+1] << 8) | tv[tp*2];
                else if (wren != 0) begin
                    if (lo) tv[tp*2] = d[7:0];
                    if (hi && tp != 3) tv[tp*2+1] = d[15:8];
                end
                if ((!w || hi) && tp > 0) tp--;
            end
            `RTCRW_OFS_ALRM_WIN: begin
                if (!w) r = (av[ap*2+1] << 8) | av[ap*2];
                else begin
                    if (lo) av[ap*2] = d[7:0];
                    if (hi) av[ap*2+1] = d[15:8];
                end
                if ((!w || hi) && ap > 0) ap--;
            end
            default: ;
        endcase
        // any transfer other than the next key byte closes the unlock sequence
        if (w && a == `RTCRW_OFS_UNLOCK_KEY && d[7:0] == `RTCRW_KEY_FIRST) ks = 1;
        else if (w && a == `RTCRW_OFS_UNLOCK_KEY && ks == 1 && d[7:0] == `RTCRW_KEY_SECOND) ks = 2;
        else ks = 0;
        return r;
    endfunction
    // ****************************************************************
    // bus tasks and checking
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // bounded wait for hready sampled high at a rising edge
    task automatic wait_rdy;
        for (int k = 0; k < 20; k++) begin
            @(posedge clk_in);
            if (hrdyo === 1'b1) return;
        end
        fail_count++;
        $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        stop_test();
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [2:0] s,
                        input logic [31:0] d, output logic [31:0] got, output logic [31:0] exp);
        @(posedge clk_in);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= `RTCRW_HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= s;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        got = hrdata & 32'hffff;  // only the 16 documented bits are compared
        exp = mdl(w, a, s, d) & 32'hffff;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x, y;
        xfer(1'b1, a, 3'h2, d, x, y);
    endtask
    task automatic rd(input logic [7:0] a);
        xfer(1'b0, a, 3'h2, 32'h0, g, e);
    endtask
    task automatic outs;
        @(negedge clk_in);
        chk({31'h0, wren_o}, wren);
        chk({30'h0, csel_o}, csel);
        chk({31'h0, hresp}, 32'h0);
    endtask
    task automatic do_reset(input int n);
        @(posedge clk_in);
        nrst_in <= 1'b0;
        repeat (n) @(posedge clk_in);
        nrst_in <= 1'b1;
        foreach (tv[j]) begin tv[j] = 0; av[j] = 0; end
        tp = 0; ap = 0; csel = 0; wren = 0; ks = 0;
    endtask
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        void'($urandom(71107));
        do_reset(20);
        for (i = 0; i < 8; i++) begin rd(8'(i * 4)); chk(g, e); end
        wr(8'h1c, 32'hffff); rd(8'h1c); chk(g, e); outs();
        $display("test reset done");
        wr(`RTCRW_OFS_CLK_CFG, 32'h2300); outs();
        wr(`RTCRW_OFS_TIME_WIN, $urandom); rd(`RTCRW_OFS_CLK_CFG); chk(g, e);
        wr(`RTCRW_OFS_UNLOCK_KEY, 32'h55); rd(`RTCRW_OFS_CLK_CFG);
        wr(`RTCRW_OFS_UNLOCK_KEY, 32'haa); wr(`RTCRW_OFS_CLK_CFG, 32'h2300); outs();
        $display("test lock done");
        wr(`RTCRW_OFS_UNLOCK_KEY, 32'h55); wr(`RTCRW_OFS_UNLOCK_KEY, 32'haa);
        wr(`RTCRW_OFS_CLK_CFG, 32'h2300); outs();
        for (i = 0; i < 5; i++) wr(`RTCRW_OFS_TIME_WIN, $urandom);
        rd(`RTCRW_OFS_CLK_CFG); chk(g, e);
        wr(`RTCRW_OFS_CLK_CFG, 32'h0300); outs();
        for (i = 0; i < 5; i++) begin rd(`RTCRW_OFS_TIME_WIN); chk(g, e); end
        wr(`RTCRW_OFS_TIME_WIN, $urandom); wr(`RTCRW_OFS_CLK_CFG, 32'h0);
        rd(`RTCRW_OFS_TIME_WIN); chk(g, e);
        $display("test time window done");
        wr(`RTCRW_OFS_ALRM_CFG, 32'h0300);
        for (i = 0; i < 4; i++) wr(`RTCRW_OFS_ALRM_WIN, $urandom);
        wr(`RTCRW_OFS_ALRM_CFG, 32'h0300);
        for (i = 0; i < 4; i++) begin rd(`RTCRW_OFS_ALRM_WIN); chk(g, e); end
        wr(`RTCRW_OFS_ALRM_CFG, 32'h0300);
        xfer(1'b0, `RTCRW_OFS_ALRM_WIN, 3'h0, 32'h0, g, e);
        xfer(1'b1, `RTCRW_OFS_ALRM_WIN, 3'h0, $urandom, g, e);
        rd(`RTCRW_OFS_ALRM_CFG); chk(g, e);
        rd(`RTCRW_OFS_ALRM_WIN); chk(g, e);
        rd(`RTCRW_OFS_ALRM_CFG); chk(g, e);
        xfer(1'b1, `RTCRW_OFS_ALRM_WIN, 3'h1, $urandom, g, e);
        wr(`RTCRW_OFS_ALRM_CFG, 32'h0100);
        xfer(1'b0, `RTCRW_OFS_ALRM_WIN, 3'h1, 32'h0, g, e); chk(g, e);
        rd(`RTCRW_OFS_ALRM_CFG); chk(g, e);
        $display("test alarm window done");
        for (i = 0; i < 4; i++) begin
            wr(`RTCRW_OFS_PWR_CTRL, i); outs();
            rd(`RTCRW_OFS_PWR_CTRL); chk(g, e);
        end
        do_reset(3); outs();
        rd(`RTCRW_OFS_CLK_CFG); chk(g, e);
        $display("test clock source done");
        stop_test();
    end
endmodule // rtcrw_top_tb
`default_nettype wire
